// file: dcsm_pkg.sv
// package: register map, field layout, codes and timing counts of the clock manager
`default_nettype none
package dcsm_pkg;
   // register offsets (byte addresses)
   localparam logic [11:0] OFS_HF_CRYSTAL_SOURCE_START = 12'h000;
   localparam logic [11:0] OFS_HF_CRYSTAL_SOURCE_STOP = 12'h004;
   localparam logic [11:0] OFS_LF_START = 12'h008;
   localparam logic [11:0] OFS_LF_STOP = 12'h00C;
   localparam logic [11:0] OFS_RC_TRIM = 12'h010;
   localparam logic [11:0] OFS_IT_START = 12'h014;
   localparam logic [11:0] OFS_IT_STOP = 12'h018;
   localparam logic [11:0] OFS_EV_HF_UP = 12'h100;
   localparam logic [11:0] OFS_EV_LF_UP = 12'h104;
   localparam logic [11:0] OFS_EV_TRIM_DONE = 12'h10C;
   localparam logic [11:0] OFS_EV_IT_EXP = 12'h110;
   localparam logic [11:0] OFS_IRQ_SET = 12'h304;
   localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
   localparam logic [11:0] OFS_HF_STAT = 12'h40C;
   localparam logic [11:0] OFS_LF_STAT = 12'h418;
   localparam logic [11:0] OFS_LF_SEL = 12'h518;
   localparam logic [11:0] OFS_IT_RELOAD = 12'h538;
   localparam logic [11:0] OFS_CRYSTAL_SOURCE_FREQ = 12'h550;
   // interrupt enable bit positions
   localparam int IRQ_BIT_HF_UP = 0;
   localparam int IRQ_BIT_LF_UP = 1;
   localparam int IRQ_BIT_TRIM_DONE = 3;
   localparam int IRQ_BIT_IT_EXP = 4;
   // status field positions
   localparam int STAT_SRC_LSB = 0;
   localparam int STAT_RUN_BIT = 16;
   // slow source codes
   localparam logic [1:0] LF_SRC_RC = 2'h0;
   localparam logic [1:0] LF_SRC_CRYSTAL = 2'h1;
   localparam logic [1:0] LF_SRC_DERIVED = 2'h2;
   // reset values
   localparam logic [1:0] LF_SEL_RESET = 2'h0;
   localparam logic [6:0] IT_RELOAD_RESET = 7'h00;
   localparam logic [7:0] CRYSTAL_SOURCE_FREQ_RESET = 8'hFF;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int SLOW_HZ = 32768;
   localparam int SLOW_DIV = CLK_HZ / SLOW_HZ; // whole cycles per slow tick
   localparam int QUARTER_SEC_TICKS = 8192; // 0.25 s of slow clock
   localparam int TRIM_SLOW_TICKS = 16; // calibration length, slow ticks
endpackage : dcsm_pkg
`default_nettype wire

// file: dcsm_tick_if.sv
// interface: slow-clock tick generator link
`default_nettype none
interface dcsm_tick_if;
   logic run;
   logic tick;
   modport gen (input run, output tick);
   modport user (output run, input tick);
endinterface : dcsm_tick_if
`default_nettype wire

// file: dcsm_tick.sv
// module: slow-clock tick generator, one pulse per 32.768 kHz period while running
`default_nettype none
module dcsm_tick
   import dcsm_pkg::*;
#(
   parameter int DIV = SLOW_DIV
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   dcsm_tick_if.gen t
);
   typedef struct packed {
      logic [10:0] cnt;
      logic tick;
   } dcsm_tk_t;
   dcsm_tk_t s;
   dcsm_tk_t next_s;
   // divider, held at zero while the slow clock is off
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (!t.run) begin
         next_s.cnt = '0;
      end else if (s.cnt == 11'(DIV - 1)) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + 11'h001;
      end
   end
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign t.tick = s.tick;
endmodule : dcsm_tick
`default_nettype wire

// file: dcsm_top.sv
// module: dual clock source manager, register file and clock sequencing
// Operation
// RULE1: fast clock is 16 MHz, slow clock 32.768 kHz, only in ON mode.
// RULE2: slow source code 0 RC, 1 crystal, 2 derived; status has running flag.
// RULE3: after reset the slow clock and all slow sources are off.
// RULE4: slow start runs selected source; RC covers until it is ready.
// RULE5: slow stop task stops the slow clock.
// RULE6: software changes slow selector only while the slow clock is stopped.
// RULE7: derived slow source needs the fast clock running.
// RULE8: fast RC oscillator runs automatically in ON mode.
// RULE9: crystal start/stop tasks control it; started event when running.
// RULE10: fast RC is off while crystal runs, back on when it stops.
// RULE11: fast RC may sleep when idle; restarts when demand returns.
// RULE12: software runs fast clock from crystal before radio or trim.
// RULE13: software sets crystal frequency selector for a 32 MHz crystal.
// RULE14: trim task with slow RC running requests fast clock, then done event.
// RULE15: software starts fast crystal before triggering trim.
// RULE16: interval timer start and stop tasks start and stop it.
// RULE17: timer counts down from reload, raises expired event at zero.
// RULE18: timer stops by itself at zero.
// RULE19: reload value is in 0.25 s units, 0.25 s to 31.75 s.
// RULE20: software issues at most one trim/timer task per slow period.
// RULE21: slow source started event once the selected source runs.
// RULE22: fast status gives source in bit 0, running in bit 16.
// RULE23: interrupt enables set by write-one set, cleared by write-one clear.
// RULE24: task writes pulse one cycle; events latch until written zero.
// RULE25: interrupt asserted while an enabled event is set.
`default_nettype none
module dcsm_top
   import dcsm_pkg::*;
#(
   parameter int HF_CRYSTAL_SOURCE_START_CYC = 16,
   parameter int LF_CRYSTAL_SOURCE_START_SLOW = 8,
   parameter int QUARTER_TICKS = QUARTER_SEC_TICKS
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_fast_demand,
   input wire logic i_cpu_sleep,
   output logic [31:0] o_rdata,
   output logic o_irq,
   output logic o_fast_rc_en,
   output logic o_fast_crystal_source_en,
   output logic o_fast_clock_run,
   output logic o_slow_rc_en,
   output logic o_slow_crystal_source_en,
   output logic o_slow_derived_en,
   output logic o_slow_clock_run,
   output logic o_trim_fast_req,
   output logic [7:0] o_crystal_source_freq
);
   typedef enum {LF_OFF, LF_STARTING, LF_RUN} dcsm_lf_t;
   typedef struct packed {
      logic [31:0] rdata;
      logic [4:0] irq_en;
      logic ev_hf, ev_lf, ev_trim, ev_it;
      logic [1:0] lf_sel;
      logic [6:0] it_reload;
      logic [7:0] crystal_source_freq;
      logic hf_crystal_source_on, hf_crystal_source_run;
      logic [7:0] hf_cnt;
      logic fast_rc_en;
      dcsm_lf_t lf_state;
      logic [1:0] lf_src;
      logic [7:0] lf_cnt;
      logic trim_busy;
      logic [4:0] trim_cnt;
      logic it_run;
      logic [19:0] it_cnt;
      logic irq;
      logic d1_dem, d2_dem, d1_slp, d2_slp;
      // registered slow source enables and slow clock run flag
      logic slow_rc_en;
      logic slow_crystal_source_en;
      logic slow_derived_en;
      logic slow_run;
   } dcsm_st_t;
   dcsm_st_t s;
   dcsm_st_t next_s;
   dcsm_tick_if tk ();
   logic wr_any;
   // slow tick generator runs with the slow clock
   dcsm_tick u_tick (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .t(tk.gen)
   );
   assign tk.run = (s.lf_state != LF_OFF);
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      return a == o;
   endfunction : hit
   // next state
   always_comb begin
      next_s = s;
      wr_any = i_wr && i_wdata[0];
      // pin synchronisers
      next_s.d1_dem = i_fast_demand;
      next_s.d2_dem = s.d1_dem;
      next_s.d1_slp = i_cpu_sleep;
      next_s.d2_slp = s.d1_slp;
      // crystal start/stop and start-up count
      if (wr_any && hit(i_addr, OFS_HF_CRYSTAL_SOURCE_START)) begin // RULE9 RULE24
         next_s.hf_crystal_source_on = 1'b1;
      end
      if (wr_any && hit(i_addr, OFS_HF_CRYSTAL_SOURCE_STOP)) begin // RULE9
         next_s.hf_crystal_source_on = 1'b0;
         next_s.hf_crystal_source_run = 1'b0;
         next_s.hf_cnt = '0;
      end
      if (s.hf_crystal_source_on && !s.hf_crystal_source_run) begin
         if (s.hf_cnt == 8'(HF_CRYSTAL_SOURCE_START_CYC - 1)) begin
            next_s.hf_crystal_source_run = 1'b1;
            next_s.ev_hf = 1'b1; // RULE9
         end else begin
            next_s.hf_cnt = s.hf_cnt + 8'h01;
         end
      end
      // fast RC: off under crystal, may sleep when idle
      next_s.fast_rc_en = !s.hf_crystal_source_run && (s.d2_dem || !s.d2_slp || s.trim_busy
                          || s.lf_src == LF_SRC_DERIVED && s.lf_state != LF_OFF); // RULE10 RULE11 RULE8
      // slow clock sequencing
      case (s.lf_state)
         LF_OFF: begin
            if (wr_any && hit(i_addr, OFS_LF_START)) begin // RULE4
               next_s.lf_cnt = '0;
               if (s.lf_sel == LF_SRC_CRYSTAL) begin
                  next_s.lf_src = LF_SRC_RC; // RULE4
                  next_s.lf_state = LF_STARTING;
               end else begin
                  next_s.lf_src = s.lf_sel;
                  next_s.lf_state = LF_RUN;
                  next_s.ev_lf = 1'b1; // RULE21
               end
            end
         end
         LF_STARTING: begin
            if (tk.tick) begin
               if (s.lf_cnt == 8'(LF_CRYSTAL_SOURCE_START_SLOW - 1)) begin
                  next_s.lf_src = LF_SRC_CRYSTAL;
                  next_s.lf_state = LF_RUN;
                  next_s.ev_lf = 1'b1; // RULE21
               end else begin
                  next_s.lf_cnt = s.lf_cnt + 8'h01;
               end
            end
         end
         LF_RUN: begin
         end
         default: next_s.lf_state = LF_OFF;
      endcase
      if (wr_any && hit(i_addr, OFS_LF_STOP)) begin // RULE5
         next_s.lf_state = LF_OFF;
         next_s.lf_src = LF_SRC_RC;
         next_s.trim_busy = 1'b0;
      end
      // slow RC trim
      if (wr_any && hit(i_addr, OFS_RC_TRIM) && s.lf_state == LF_RUN
          && s.lf_src == LF_SRC_RC) begin // RULE14
         next_s.trim_busy = 1'b1;
         next_s.trim_cnt = '0;
      end else if (s.trim_busy && tk.tick) begin
         if (s.trim_cnt == 5'(TRIM_SLOW_TICKS - 1)) begin
            next_s.trim_busy = 1'b0;
            next_s.ev_trim = 1'b1; // RULE14
         end else begin
            next_s.trim_cnt = s.trim_cnt + 5'h01;
         end
      end
      // interval timer, counts slow ticks
      if (wr_any && hit(i_addr, OFS_IT_START)) begin // RULE16 RULE17
         next_s.it_run = 1'b1;
         next_s.it_cnt = 20'(s.it_reload * QUARTER_TICKS); // RULE19
      end else if (wr_any && hit(i_addr, OFS_IT_STOP)) begin // RULE16
         next_s.it_run = 1'b0;
      end else if (s.it_run && tk.tick) begin
         if (s.it_cnt <= 20'h00001) begin
            next_s.it_cnt = '0;
            next_s.it_run = 1'b0; // RULE18
            next_s.ev_it = 1'b1; // RULE17
         end else begin
            next_s.it_cnt = s.it_cnt - 20'h00001;
         end
      end
      // register writes; event set wins over a clear in the same cycle unless the event was already set
      if (i_wr) begin
         if (hit(i_addr, OFS_EV_HF_UP) && !i_wdata[0] && next_s.ev_hf == s.ev_hf) begin
            next_s.ev_hf = 1'b0; // RULE24
         end
         if (hit(i_addr, OFS_EV_LF_UP) && !i_wdata[0] && next_s.ev_lf == s.ev_lf) begin
            next_s.ev_lf = 1'b0;
         end
         if (hit(i_addr, OFS_EV_TRIM_DONE) && !i_wdata[0] && next_s.ev_trim == s.ev_trim) begin
            next_s.ev_trim = 1'b0;
         end
         if (hit(i_addr, OFS_EV_IT_EXP) && !i_wdata[0] && next_s.ev_it == s.ev_it) begin
            next_s.ev_it = 1'b0;
         end
         if (hit(i_addr, OFS_IRQ_SET)) begin
            next_s.irq_en = s.irq_en | i_wdata[4:0]; // RULE23
         end
         if (hit(i_addr, OFS_IRQ_CLR)) begin
            next_s.irq_en = s.irq_en & ~i_wdata[4:0]; // RULE23
         end
         if (hit(i_addr, OFS_LF_SEL)) begin
            next_s.lf_sel = i_wdata[1:0]; // RULE6
         end
         if (hit(i_addr, OFS_IT_RELOAD)) begin
            next_s.it_reload = i_wdata[6:0];
         end
         if (hit(i_addr, OFS_CRYSTAL_SOURCE_FREQ)) begin
            next_s.crystal_source_freq = i_wdata[7:0]; // RULE13
         end
      end
      next_s.irq = (next_s.ev_hf && next_s.irq_en[IRQ_BIT_HF_UP])
                || (next_s.ev_lf && next_s.irq_en[IRQ_BIT_LF_UP])
                || (next_s.ev_trim && next_s.irq_en[IRQ_BIT_TRIM_DONE])
                || (next_s.ev_it && next_s.irq_en[IRQ_BIT_IT_EXP]); // RULE25
      // slow enables from the next state, so the pins come from flops
      next_s.slow_run = next_s.lf_state != LF_OFF; // RULE3
      next_s.slow_rc_en = next_s.slow_run && next_s.lf_src == LF_SRC_RC; // RULE4
      next_s.slow_crystal_source_en = next_s.slow_run && next_s.lf_sel == LF_SRC_CRYSTAL; // RULE4
      next_s.slow_derived_en = next_s.slow_run && next_s.lf_src == LF_SRC_DERIVED; // RULE7
      // read data, one cycle later, zero otherwise
      next_s.rdata = '0;
      if (i_rd) begin
         case (i_addr)
            OFS_EV_HF_UP: next_s.rdata = {31'h0, s.ev_hf};
            OFS_EV_LF_UP: next_s.rdata = {31'h0, s.ev_lf};
            OFS_EV_TRIM_DONE: next_s.rdata = {31'h0, s.ev_trim};
            OFS_EV_IT_EXP: next_s.rdata = {31'h0, s.ev_it};
            OFS_IRQ_SET, OFS_IRQ_CLR: next_s.rdata = {27'h0, s.irq_en};
            OFS_HF_STAT: begin
               next_s.rdata[STAT_SRC_LSB] = s.hf_crystal_source_run; // RULE22
               next_s.rdata[STAT_RUN_BIT] = 1'b1;
            end
            OFS_LF_STAT: begin
               next_s.rdata[STAT_SRC_LSB+:2] = s.lf_src; // RULE2
               next_s.rdata[STAT_RUN_BIT] = s.lf_state != LF_OFF;
            end
            OFS_LF_SEL: next_s.rdata = {30'h0, s.lf_sel};
            OFS_IT_RELOAD: next_s.rdata = {25'h0, s.it_reload};
            OFS_CRYSTAL_SOURCE_FREQ: next_s.rdata = {24'h0, s.crystal_source_freq};
            default: next_s.rdata = '0;
         endcase
      end
   end
   // state register; reset leaves slow side off, fast RC on
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s <= '{rdata: '0, irq_en: '0, ev_hf: 1'b0, ev_lf: 1'b0, ev_trim: 1'b0,
                ev_it: 1'b0, lf_sel: LF_SEL_RESET, it_reload: IT_RELOAD_RESET,
                crystal_source_freq: CRYSTAL_SOURCE_FREQ_RESET, hf_crystal_source_on: 1'b0, hf_crystal_source_run: 1'b0,
                hf_cnt: '0, fast_rc_en: 1'b1, lf_state: LF_OFF, lf_src: LF_SRC_RC,
                lf_cnt: '0, trim_busy: 1'b0, trim_cnt: '0, it_run: 1'b0,
                it_cnt: '0, irq: 1'b0, d1_dem: 1'b0, d2_dem: 1'b0,
                d1_slp: 1'b0, d2_slp: 1'b0, slow_rc_en: 1'b0, slow_crystal_source_en: 1'b0,
                slow_derived_en: 1'b0, slow_run: 1'b0}; // RULE3 RULE8
      end else begin
         s <= next_s;
      end
   end
   // outputs straight from state flops, except fast clock run, which is tied high
   assign o_rdata = s.rdata;
   assign o_irq = s.irq;
   assign o_fast_rc_en = s.fast_rc_en;
   assign o_fast_crystal_source_en = s.hf_crystal_source_on;
   assign o_fast_clock_run = 1'b1; // RULE1
   assign o_slow_rc_en = s.slow_rc_en;
   assign o_slow_crystal_source_en = s.slow_crystal_source_en;
   assign o_slow_derived_en = s.slow_derived_en; // RULE7
   assign o_slow_clock_run = s.slow_run;
   assign o_trim_fast_req = s.trim_busy;
   assign o_crystal_source_freq = s.crystal_source_freq;
   // assertions
   trim_done_ev_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $fell(s.trim_busy) && s.lf_state != LF_OFF |-> s.ev_trim) // RULE14
      else $error("trim end without done event");
   lf_stop_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_wdata[0] && i_addr == OFS_LF_STOP |=> !o_slow_clock_run) // RULE5
      else $error("slow clock still runs after stop");
   lf_start_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_wdata[0] && i_addr == OFS_LF_START && !o_slow_clock_run
      |=> o_slow_clock_run && s.lf_src == (s.lf_sel == LF_SRC_CRYSTAL ? LF_SRC_RC : s.lf_sel)) // RULE4
      else $error("slow start wrong source");
   hf_rc_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s.hf_crystal_source_run |=> !o_fast_rc_en) // RULE10
      else $error("fast RC on under crystal");
   hf_up_ev_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(s.hf_crystal_source_run) |-> s.ev_hf) // RULE9
      else $error("crystal up without event");
   it_stop_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(s.ev_it) |-> !s.it_run && s.it_cnt == 20'h0) // RULE17 RULE18
      else $error("timer expiry wrong");
   irq_en_set_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_addr == OFS_IRQ_SET |=> (s.irq_en & $past(i_wdata[4:0])) == $past(i_wdata[4:0])) // RULE23
      else $error("enable set failed");
   irq_out_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_irq == ((s.ev_hf && s.irq_en[0]) || (s.ev_lf && s.irq_en[1])
      || (s.ev_trim && s.irq_en[3]) || (s.ev_it && s.irq_en[4]))) // RULE25
      else $error("interrupt mismatch");
   hf_stat_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_rd && i_addr == OFS_HF_STAT |=> o_rdata[16] && o_rdata[0] == $past(s.hf_crystal_source_run)) // RULE22
      else $error("fast status wrong");
   // slow side assertions
   slow_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !o_slow_clock_run |-> !o_slow_rc_en && !o_slow_crystal_source_en && !o_slow_derived_en) // RULE3
      else $error("slow source on while slow clock off");
   slow_any_src_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_slow_clock_run |-> o_slow_rc_en || o_slow_crystal_source_en || o_slow_derived_en) // RULE4
      else $error("slow clock runs without a source");
   lf_crystal_source_up_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(s.lf_src == LF_SRC_CRYSTAL) |-> s.ev_lf && s.lf_state == LF_RUN) // RULE21
      else $error("crystal slow source up without event");
   trim_rc_only_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(s.trim_busy) |-> $past(s.lf_state) == LF_RUN && $past(s.lf_src) == LF_SRC_RC) // RULE14
      else $error("trim started without slow RC");
   trim_stop_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_wdata[0] && i_addr == OFS_LF_STOP |=> !o_trim_fast_req) // RULE5
      else $error("trim request held after slow stop");
   it_load_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_wdata[0] && i_addr == OFS_IT_START
      |=> s.it_run && s.it_cnt == 20'($past(s.it_reload) * QUARTER_TICKS)) // RULE17 RULE19
      else $error("timer not loaded from reload");
   // fast side, events and enables
   hf_crystal_source_en_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_wdata[0] && i_addr == OFS_HF_CRYSTAL_SOURCE_START |=> o_fast_crystal_source_en) // RULE9
      else $error("crystal enable missing after start");
   hf_rc_back_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $fell(s.hf_crystal_source_run) && s.d2_dem |=> o_fast_rc_en) // RULE10
      else $error("fast RC not back after crystal stop");
   ev_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_addr == OFS_EV_HF_UP && !i_wdata[0] && s.hf_crystal_source_run |=> !s.ev_hf) // RULE24
      else $error("event not cleared by write of zero");
   irq_en_clr_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_addr == OFS_IRQ_CLR |=> (s.irq_en & $past(i_wdata[4:0])) == 5'h00) // RULE23
      else $error("enable clear failed");
   hf_up_c: cover property (@(posedge i_clk) $rose(s.hf_crystal_source_run));
   lf_start_c: cover property (@(posedge i_clk) $rose(s.ev_lf));
   trim_c: cover property (@(posedge i_clk) $rose(s.ev_trim));
   it_exp_c: cover property (@(posedge i_clk) $rose(s.ev_it));
   irq_c: cover property (@(posedge i_clk) $rose(o_irq));
endmodule : dcsm_top
`default_nettype wire

// file: dcsm_top_tb.sv
// testbench: self-checking bench for the dual clock source manager
`default_nettype none
module dcsm_top_tb
   import dcsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // signals and design instance
   localparam int QT = 2;
   localparam int HFX = 16;
   localparam int LFX = 8;
   localparam int TICK = SLOW_DIV;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } dcsm_row_t;
   logic clk, reset_n, wr_s, rd_s, demand, sleep;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, d;
   logic irq, frc, fx, frun, s_rc, s_xt, s_dv, srun, treq;
   logic [7:0] xfreq;
   int n_mismatch, n_checks, c;
   dcsm_row_t rows [10];
   // clock at 20 MHz
   always #25 clk = ~clk;
   dcsm_top #(.HF_CRYSTAL_SOURCE_START_CYC(HFX), .LF_CRYSTAL_SOURCE_START_SLOW(LFX), .QUARTER_TICKS(QT)) i_dcsm_top (
      .i_clk(clk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
      .i_rd(rd_s), .i_fast_demand(demand), .i_cpu_sleep(sleep), .o_rdata(rdata),
      .o_irq(irq), .o_fast_rc_en(frc), .o_fast_crystal_source_en(fx), .o_fast_clock_run(frun),
      .o_slow_rc_en(s_rc), .o_slow_crystal_source_en(s_xt), .o_slow_derived_en(s_dv),
      .o_slow_clock_run(srun), .o_trim_fast_req(treq), .o_crystal_source_freq(xfreq));
   // ==========================================================
   // checking and bus tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the read edge
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      v = rdata;
   endtask : rd
   task automatic chk_rd(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk(what, v, exp);
   endtask : chk_rd
   // bounded wait for the interrupt line
   task automatic wait_irq(input int lim, output int cyc);
      cyc = 0;
      while (irq !== 1'b1) begin
         @(posedge clk);
         #1;
         cyc++;
         if (cyc > lim) begin
            chk("irq wait", 32'h0, 32'h1);
            complete_run();
         end
      end
   endtask : wait_irq
   // ==========================================================
   // main sequence
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      wr_s = 1'b0;
      rd_s = 1'b0;
      addr = 12'h000;
      wdata = 32'h0;
      demand = 1'b1;
      sleep = 1'b0;
      n_mismatch = 0;
      n_checks = 0;
      rows = '{'{OFS_LF_SEL, 32'h1, 32'h1}, '{OFS_LF_SEL, 32'h2, 32'h2},
               '{OFS_LF_SEL, 32'h0, 32'h0}, '{OFS_IT_RELOAD, 32'hFFFFFFFF, 32'h7F},
               '{OFS_IT_RELOAD, 32'h1, 32'h1}, '{OFS_CRYSTAL_SOURCE_FREQ, 32'h0, 32'h0},
               '{OFS_CRYSTAL_SOURCE_FREQ, 32'hFF, 32'hFF}, '{12'h020, 32'h1, 32'h0},
               '{OFS_HF_CRYSTAL_SOURCE_STOP, 32'h1, 32'h0}, '{OFS_LF_STOP, 32'h1, 32'h0}};
      wait_cyc(4);
      chk("fast rc in reset", frc, 1'b1);
      chk("slow in reset", {s_rc, s_xt, s_dv, srun, fx, irq}, 32'h0);
      chk("freq in reset", xfreq, 8'hFF);
      @(posedge clk);
      reset_n <= 1'b1;
      chk_rd("hf stat", OFS_HF_STAT, 32'h00010000);
      chk_rd("lf stat", OFS_LF_STAT, 32'h0);
      chk_rd("reload reset", OFS_IT_RELOAD, 32'h0);
      $display("test reset done");
      // register rows: write then read back
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         chk_rd("row read", rows[i].addr, rows[i].exp);
      end
      chk("freq pin", xfreq, 8'hFF);
      $display("test registers done");
      // fast crystal start, event, interrupt enables
      wr(OFS_IRQ_SET, 32'h1);
      wr(OFS_RC_TRIM, 32'h1);
      wait_cyc(2);
      chk("trim refused", treq, 1'b0);
      chk("irq idle", irq, 1'b0);
      wr(OFS_HF_CRYSTAL_SOURCE_START, 32'h1);
      wait_cyc(2);
      chk("crystal_source on", fx, 1'b1);
      wait_irq(HFX + 8, c);
      wait_cyc(1);
      chk("fast rc off", frc, 1'b0);
      chk_rd("hf stat crystal_source", OFS_HF_STAT, 32'h00010001);
      chk_rd("hf event", OFS_EV_HF_UP, 32'h1);
      wr(OFS_IRQ_CLR, 32'h1);
      wait_cyc(1);
      chk("irq masked", irq, 1'b0);
      wr(OFS_IRQ_SET, 32'h1);
      wait_cyc(1);
      chk("irq unmasked", irq, 1'b1);
      wr(OFS_EV_HF_UP, 32'h0);
      wait_cyc(1);
      chk("irq cleared", irq, 1'b0);
      wr(OFS_IRQ_CLR, 32'h1);
      wr(OFS_HF_CRYSTAL_SOURCE_STOP, 32'h1);
      wait_cyc(2);
      chk("crystal_source stop", {fx, frc}, 2'b01);
      sleep <= 1'b1;
      demand <= 1'b0;
      wait_cyc(6);
      chk("fast rc idle", frc, 1'b0);
      demand <= 1'b1;
      wait_cyc(6);
      chk("fast rc back", frc, 1'b1);
      sleep <= 1'b0;
      wr(OFS_HF_CRYSTAL_SOURCE_START, 32'h1);
      wait_cyc(HFX + 8);
      $display("test fast clock done");
      // each slow source code in turn
      for (int s = 0; s < 3; s++) begin
         wr(OFS_LF_SEL, 32'(s));
         wr(OFS_IRQ_SET, 32'h2);
         wr(OFS_LF_START, 32'h1);
         wait_cyc(2);
         chk("slow run", srun, 1'b1);
         chk("cover en", {s_rc, s_xt, s_dv}, (s == 2) ? 3'b001 : (s == 1) ? 3'b110 : 3'b100);
         wait_irq((LFX + 4) * TICK, c);
         if (s == 1) begin
            chk("cover span", c > (LFX - 1) * TICK, 1'b1);
         end
         chk_rd("lf stat run", OFS_LF_STAT, 32'h00010000 | 32'(s));
         chk("source en", {s_rc, s_xt, s_dv}, {s == 0, s == 1, s == 2});
         wr(OFS_EV_LF_UP, 32'h0);
         wr(OFS_IRQ_CLR, 32'h2);
         wr(OFS_LF_STOP, 32'h1);
         wait_cyc(2);
         chk("slow stop", {s_rc, s_xt, s_dv, srun}, 4'h0);
         chk_rd("lf stat stop", OFS_LF_STAT, 32'h0);
      end
      $display("test slow sources done");
      // trim with the slow RC selected, then the interval timer
      wr(OFS_LF_SEL, 32'h0);
      wr(OFS_LF_START, 32'h1);
      wr(OFS_IRQ_SET, 32'h8);
      wr(OFS_RC_TRIM, 32'h1);
      wait_cyc(2);
      chk("trim request", treq, 1'b1);
      wait_irq((TRIM_SLOW_TICKS + 4) * TICK, c);
      chk("trim span", c > (TRIM_SLOW_TICKS - 1) * TICK, 1'b1);
      chk("trim release", treq, 1'b0);
      wr(OFS_EV_TRIM_DONE, 32'h0);
      wr(OFS_IRQ_CLR, 32'h8);
      wr(OFS_IRQ_SET, 32'h10);
      wait_cyc(TICK + 4);
      wr(OFS_IT_START, 32'h1);
      wait_irq((QT + 2) * TICK, c);
      chk("timer span", c > (QT - 1) * TICK && c <= QT * TICK + 4, 1'b1);
      wr(OFS_EV_IT_EXP, 32'h0);
      wait_cyc(3 * QT * TICK);
      chk_rd("timer halted", OFS_EV_IT_EXP, 32'h0);
      wr(OFS_IT_RELOAD, 32'h2);
      wr(OFS_IT_START, 32'h1);
      wait_cyc(TICK + 4);
      wr(OFS_IT_STOP, 32'h1);
      wait_cyc(3 * QT * TICK);
      chk_rd("timer stopped", OFS_EV_IT_EXP, 32'h0);
      chk("irq quiet", irq, 1'b0);
      $display("test trim and timer done");
      complete_run();
   end
endmodule : dcsm_top_tb
`default_nettype wire
